/* hw/fcsu_ctrl.sv */
// Host-side controller that sequences commands to a boot-block flash device
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
// Overview of operation
// R1 - 70H write switches reads to status
// R2 - 90H then reads give maker/part code
// R3 - Program: 40H or 10H, then data
// R4 - Second program write carries target address, data
// R5 - Erase: 20H then D0H inside block
// R6 - Upper data byte of commands ignored
// R7 - Test ready bit before result bits
// R8 - Suspend halts erase, sets ready, suspended
// R9 - Suspended holds until D0H resume
// R10 - Erase fault on bad supply or pulses
// R11 - Program fault on bad supply or pulses
// R12 - Bad erase confirm sets bits 4, 5
// R13 - Supply sampled only once sequence entered
// R14 - Host masks reserved status bits 2..0
// R15 - Low supply blocks attempts until cleared
// R16 - Erase fault accumulates until 50H clear
// R17 - Clear status after any detected error
// R18 - Only boot block locks independently
// R19 - Low supply fails every program/erase
// R20 - FFH at any address reads array
// R21 - Engine only sets failure bits
// R22 - Completion switches reads to status
// R23 - Reset starts in array read, flags cleared
// R24 - Suspended: only read, status, resume accepted; code refuses only program and erase
module fcsu_ctrl #(
  parameter int POLL_LIMIT = fcsu_pkg::POLL_LIMIT
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  // Register port
  input wire logic [fcsu_pkg::REG_AW-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Flash pins
  output logic [fcsu_pkg::ADDR_W-1:0] FL_ADDR_O,
  input wire logic [fcsu_pkg::DATA_W-1:0] FL_DQ_I,
  output logic [fcsu_pkg::DATA_W-1:0] FL_DQ_O,
  output logic FL_DQ_OE_O,
  output logic FL_CE_N_O,
  output logic FL_WE_N_O,
  output logic FL_OE_N_O,
  output logic FL_RP_N_O
);
  fcsu_cyc_if cyc ();
  fcsu_pkg::fcsu_state_t state_q;
  fcsu_pkg::fcsu_op_t op_q;
  logic wait_q;
  logic autoclr_q;
  logic [fcsu_pkg::ADDR_W-1:0] addr_q;
  logic [fcsu_pkg::DATA_W-1:0] wdata_q;
  logic [fcsu_pkg::DATA_W-1:0] rdata_q;
  logic [7:0] stat_byte_q;
  logic susp_q;
  logic refused_q;
  logic timeout_q;
  logic error_q;
  logic lowsup_q;
  logic req_q;
  logic we_q;
  logic [fcsu_pkg::ADDR_W-1:0] cyc_addr_q;
  logic [fcsu_pkg::DATA_W-1:0] cyc_wdata_q;
  logic expired;
  logic start;
  logic refuse;
  logic [7:0] poll_byte;
  logic poll_err;
  fcsu_pkg::fcsu_op_t new_op;

  // ==========================================================================
  // Helpers
  // Command byte in the low lane, upper lane held low to keep current down
  function automatic logic [fcsu_pkg::DATA_W-1:0] cmd_word(input logic [7:0] code);
    cmd_word = {8'h00, code}; // R6
  endfunction

  // First-cycle command byte of each operation
  function automatic logic [7:0] op_code(input fcsu_pkg::fcsu_op_t op);
    case (op)
      fcsu_pkg::OP_RD_ARRAY: op_code = fcsu_pkg::CMD_READ_ARRAY; // R20
      fcsu_pkg::OP_RD_ID: op_code = fcsu_pkg::CMD_READ_ID; // R2
      fcsu_pkg::OP_RD_STATUS: op_code = fcsu_pkg::CMD_READ_STATUS; // R1
      fcsu_pkg::OP_CLR_STATUS: op_code = fcsu_pkg::CMD_CLEAR_STATUS;
      fcsu_pkg::OP_PROGRAM: op_code = fcsu_pkg::CMD_PROGRAM; // R3
      fcsu_pkg::OP_ERASE: op_code = fcsu_pkg::CMD_ERASE_SETUP; // R5
      fcsu_pkg::OP_SUSPEND: op_code = fcsu_pkg::CMD_SUSPEND;
      default: op_code = fcsu_pkg::CMD_CONFIRM; // R9
    endcase
  endfunction

  // ==========================================================================
  // Leaf engines
  fcsu_bus_cycle u_bus (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .cyc(cyc.slave),
    .dq_i(FL_DQ_I),
    .addr_o(FL_ADDR_O),
    .dq_o(FL_DQ_O),
    .dq_oe_o(FL_DQ_OE_O),
    .ce_n_o(FL_CE_N_O),
    .we_n_o(FL_WE_N_O),
    .oe_n_o(FL_OE_N_O)
  );

  // Long waits are bounded so a dead device cannot hang the controller
  fcsu_timer #(.LIMIT(POLL_LIMIT)) u_timer (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .run_i(state_q == fcsu_pkg::S_POLL),
    .expired_o(expired)
  );

  assign cyc.req = req_q;
  assign cyc.we = we_q;
  assign cyc.addr = cyc_addr_q;
  assign cyc.wdata = cyc_wdata_q;

  // ==========================================================================
  // Decode of a start request
  assign start = WR_I && (ADDR_I == fcsu_pkg::REG_CTRL) && (state_q == fcsu_pkg::S_IDLE);
  assign new_op = fcsu_pkg::fcsu_op_t'(WDATA_I[fcsu_pkg::CTRL_OP_LSB +: 3]);
  // Program and erase are kept off the device while suspended or low supply seen
  assign refuse = ((new_op == fcsu_pkg::OP_PROGRAM) || (new_op == fcsu_pkg::OP_ERASE))
                  && (susp_q || lowsup_q); // R15 R24
  // Reserved bits are masked before the sequencer and stat_byte_q use the status byte; rdata_q keeps them
  assign poll_byte = cyc.rdata[7:0] & fcsu_pkg::SB_KEEP_MASK; // R14
  assign poll_err = poll_byte[fcsu_pkg::SB_WIPE] || poll_byte[fcsu_pkg::SB_WRITE]
                    || poll_byte[fcsu_pkg::SB_LOW];

  // ==========================================================================
  // Reset pin: device held in reset while the controller is
  always_ff @(posedge CLK_SYS_I) begin
    FL_RP_N_O <= RESETN_I; // R23
  end

  // ==========================================================================
  // Operation parameters latched from software
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      addr_q <= '0;
      wdata_q <= '0;
      autoclr_q <= 1'b0;
      op_q <= fcsu_pkg::OP_RD_ARRAY;
    end else if (WR_I && ADDR_I == fcsu_pkg::REG_ADDR) begin
      addr_q <= WDATA_I[fcsu_pkg::ADDR_W-1:0];
    end else if (WR_I && ADDR_I == fcsu_pkg::REG_WDATA) begin
      wdata_q <= WDATA_I[fcsu_pkg::DATA_W-1:0];
    end else if (start && !refuse) begin
      op_q <= new_op;
      autoclr_q <= WDATA_I[fcsu_pkg::CTRL_AUTOCLR];
    end
  end

  // ==========================================================================
  // Command sequencer: one bus cycle per state visit after S_IDLE, except S_POLL, which repeats cycles until ready or timeout
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      state_q <= fcsu_pkg::S_IDLE;
      wait_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      cyc_addr_q <= '0;
      cyc_wdata_q <= '0;
    end else begin
      req_q <= 1'b0;
      case (state_q)
        fcsu_pkg::S_IDLE: begin
          if (start && !refuse) begin
            state_q <= fcsu_pkg::S_CMD1;
          end
        end
        fcsu_pkg::S_CMD1: begin
          if (!wait_q) begin
            req_q <= 1'b1;
            wait_q <= 1'b1;
            we_q <= 1'b1;
            cyc_addr_q <= addr_q; // R5
            cyc_wdata_q <= cmd_word(op_code(op_q)); // R1 R2 R3 R20
          end else if (cyc.done) begin
            wait_q <= 1'b0;
            case (op_q)
              fcsu_pkg::OP_CLR_STATUS: state_q <= fcsu_pkg::S_IDLE;
              fcsu_pkg::OP_PROGRAM, fcsu_pkg::OP_ERASE: state_q <= fcsu_pkg::S_CMD2;
              fcsu_pkg::OP_SUSPEND, fcsu_pkg::OP_RESUME: state_q <= fcsu_pkg::S_POLL;
              default: state_q <= fcsu_pkg::S_READ;
            endcase
          end
        end
        fcsu_pkg::S_CMD2: begin
          if (!wait_q) begin
            req_q <= 1'b1;
            wait_q <= 1'b1;
            cyc_addr_q <= addr_q; // R4 R5
            cyc_wdata_q <= (op_q == fcsu_pkg::OP_PROGRAM) ? wdata_q
                           : cmd_word(fcsu_pkg::CMD_CONFIRM); // R4 R5
          end else if (cyc.done) begin
            wait_q <= 1'b0;
            state_q <= fcsu_pkg::S_POLL; // R22
          end
        end
        fcsu_pkg::S_READ, fcsu_pkg::S_POLL: begin
          // Timeout is only honoured between cycles so the pins end cleanly
          if (!wait_q && expired) begin
            state_q <= fcsu_pkg::S_IDLE;
          end else if (!wait_q) begin
            req_q <= 1'b1;
            wait_q <= 1'b1;
            we_q <= 1'b0;
            cyc_addr_q <= addr_q; // R2
          end else if (cyc.done) begin
            wait_q <= 1'b0;
            if (state_q == fcsu_pkg::S_READ) begin
              state_q <= fcsu_pkg::S_IDLE;
            end else if (poll_byte[fcsu_pkg::SB_READY]) begin // R7
              state_q <= (poll_err && autoclr_q) ? fcsu_pkg::S_CLEAR
                         : fcsu_pkg::S_IDLE; // R17
            end
          end
        end
        default: begin
          if (!wait_q) begin
            req_q <= 1'b1;
            wait_q <= 1'b1;
            we_q <= 1'b1;
            cyc_wdata_q <= cmd_word(fcsu_pkg::CMD_CLEAR_STATUS); // R17
          end else if (cyc.done) begin
            wait_q <= 1'b0;
            state_q <= fcsu_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Read data and last status byte captured from the device
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      rdata_q <= '0;
      stat_byte_q <= 8'h00;
    end else if (cyc.done && !we_q) begin
      rdata_q <= cyc.rdata;
      if (state_q == fcsu_pkg::S_POLL || op_q == fcsu_pkg::OP_RD_STATUS) begin
        stat_byte_q <= poll_byte; // R14
      end
    end
  end

  // ==========================================================================
  // Sticky flags: software clears by writing one, a new event wins the cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      refused_q <= 1'b0;
      timeout_q <= 1'b0;
      error_q <= 1'b0;
    end else begin
      refused_q <= (start && refuse)
                   || (refused_q && !(WR_I && ADDR_I == fcsu_pkg::REG_STATUS
                                      && WDATA_I[fcsu_pkg::ST_REFUSED]));
      timeout_q <= (state_q == fcsu_pkg::S_POLL && !wait_q && expired)
                   || (timeout_q && !(WR_I && ADDR_I == fcsu_pkg::REG_STATUS
                                      && WDATA_I[fcsu_pkg::ST_TIMEOUT]));
      // Result bits are trusted only with the ready bit set
      error_q <= (state_q == fcsu_pkg::S_POLL && cyc.done
                  && poll_byte[fcsu_pkg::SB_READY] && poll_err) // R7
                 || (error_q && !(WR_I && ADDR_I == fcsu_pkg::REG_STATUS
                                  && WDATA_I[fcsu_pkg::ST_ERROR]));
    end
  end

  // ==========================================================================
  // Device-side state mirrored from polls; low supply drops only on a clear command
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      susp_q <= 1'b0;
      lowsup_q <= 1'b0;
    end else if (state_q == fcsu_pkg::S_POLL && cyc.done && poll_byte[fcsu_pkg::SB_READY]) begin
      susp_q <= poll_byte[fcsu_pkg::SB_SUSP];
      lowsup_q <= lowsup_q || poll_byte[fcsu_pkg::SB_LOW]; // R15
    end else if (cyc.done && we_q && cyc_wdata_q == cmd_word(fcsu_pkg::CMD_CLEAR_STATUS)) begin
      lowsup_q <= 1'b0; // R15
    end
  end

  // ==========================================================================
  // Register read port, data in the cycle after the strobe
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      RDATA_O <= fcsu_pkg::RDATA_RESET;
    end else if (RD_I) begin
      if (ADDR_I == fcsu_pkg::REG_CTRL) begin
        RDATA_O <= {27'h0000000, autoclr_q, 1'b0, op_q};
      end else if (ADDR_I == fcsu_pkg::REG_ADDR) begin
        RDATA_O <= 32'(addr_q);
      end else if (ADDR_I == fcsu_pkg::REG_WDATA) begin
        RDATA_O <= 32'(wdata_q);
      end else if (ADDR_I == fcsu_pkg::REG_STATUS) begin
        RDATA_O <= {16'h0000, stat_byte_q, 2'b00, lowsup_q, error_q, timeout_q,
                    refused_q, susp_q, state_q != fcsu_pkg::S_IDLE};
      end else if (ADDR_I == fcsu_pkg::REG_RDATA) begin
        RDATA_O <= 32'(rdata_q);
      end else begin
        RDATA_O <= 32'h0000_0000;
      end
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Checks
  status_cmd_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R1
    req_q && state_q == fcsu_pkg::S_CMD1 && op_q == fcsu_pkg::OP_RD_STATUS
    |-> cyc_wdata_q == 16'h0070 && we_q)
    else $error("status read not preceded by 70H");
  id_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R2
    cyc.done && state_q == fcsu_pkg::S_CMD1 && op_q == fcsu_pkg::OP_RD_ID
    |=> state_q == fcsu_pkg::S_READ ##1 req_q && !we_q && cyc_addr_q[0] == addr_q[0])
    else $error("identifier read missing after 90H");
  prog_setup_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R3
    req_q && state_q == fcsu_pkg::S_CMD1 && op_q == fcsu_pkg::OP_PROGRAM
    |-> cyc_wdata_q == 16'h0040 && cyc_addr_q == addr_q)
    else $error("program setup code wrong");
  prog_data_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R4
    req_q && state_q == fcsu_pkg::S_CMD2 && op_q == fcsu_pkg::OP_PROGRAM
    |-> we_q && cyc_wdata_q == wdata_q && cyc_addr_q == addr_q)
    else $error("program data cycle wrong");
  erase_pair_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R5
    req_q && state_q == fcsu_pkg::S_CMD2 && op_q == fcsu_pkg::OP_ERASE
    |-> cyc_wdata_q == 16'h00d0 && $stable(cyc_addr_q))
    else $error("erase confirm wrong");
  upper_low_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R6
    req_q && we_q && state_q != fcsu_pkg::S_CMD2 |-> cyc_wdata_q[15:8] == 8'h00)
    else $error("command upper byte not low");
  ready_first_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R7
    state_q == fcsu_pkg::S_POLL && cyc.done && !poll_byte[fcsu_pkg::SB_READY]
    |=> state_q == fcsu_pkg::S_POLL && $stable(error_q) ##1 req_q || expired)
    else $error("result used while busy");
  mask_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R14
    $changed(stat_byte_q) |-> stat_byte_q[2:0] == 3'b000)
    else $error("reserved status bits kept");
  lowsup_block_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R15
    start && lowsup_q && new_op == fcsu_pkg::OP_ERASE
    |=> state_q == fcsu_pkg::S_IDLE && refused_q)
    else $error("erase attempted with low supply");
  auto_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R17
    state_q == fcsu_pkg::S_POLL && cyc.done && poll_byte[fcsu_pkg::SB_READY] && poll_err
    && autoclr_q |=> ##1 req_q && cyc_wdata_q == 16'h0050)
    else $error("status not cleared after error");
  array_cmd_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // R20
    req_q && state_q == fcsu_pkg::S_CMD1 && op_q == fcsu_pkg::OP_RD_ARRAY
    |-> cyc_wdata_q == 16'h00ff)
    else $error("array read code wrong");
  prog_done_c: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    state_q == fcsu_pkg::S_POLL && op_q == fcsu_pkg::OP_PROGRAM ##1 state_q == fcsu_pkg::S_IDLE);
  erase_err_c: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    state_q == fcsu_pkg::S_CLEAR && op_q == fcsu_pkg::OP_ERASE);
  suspend_c: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) $rose(susp_q));
  refuse_c: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) $rose(refused_q));
endmodule // fcsu_ctrl

/* hw/fcsu_pkg.sv */
// Shared constants and types of the flash command and status controller
package fcsu_pkg;
  // ==========================================================================
  // Widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int REG_AW = 4;
  // ==========================================================================
  // Device command bytes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  // ==========================================================================
  // Device status byte fields
  localparam int SB_READY = 7;
  localparam int SB_SUSP = 6;
  localparam int SB_WIPE = 5;
  localparam int SB_WRITE = 4;
  localparam int SB_LOW = 3;
  localparam logic [7:0] SB_KEEP_MASK = 8'hf8;
  // ==========================================================================
  // Controller registers
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_ADDR = 4'h1;
  localparam logic [REG_AW-1:0] REG_WDATA = 4'h2;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h3;
  localparam logic [REG_AW-1:0] REG_RDATA = 4'h4;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_AUTOCLR = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_SUSP = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_ERROR = 4;
  localparam int ST_LOWSUP = 5;
  localparam int ST_BYTE_LSB = 8;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 70;
  localparam int RECOVER_NS = 30;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_LIMIT = 100000;
  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    OP_RD_ARRAY, OP_RD_ID, OP_RD_STATUS, OP_CLR_STATUS,
    OP_PROGRAM, OP_ERASE, OP_SUSPEND, OP_RESUME
  } fcsu_op_t;
  typedef enum logic [2:0] {S_IDLE, S_CMD1, S_CMD2, S_READ, S_POLL, S_CLEAR} fcsu_state_t;
endpackage

/* hw/fcsu_cyc_if.sv */
// Request and answer of one flash bus cycle between sequencer and pin engine
`timescale 1ns/100ps
interface fcsu_cyc_if;
  logic req;
  logic we;
  logic [fcsu_pkg::ADDR_W-1:0] addr;
  logic [fcsu_pkg::DATA_W-1:0] wdata;
  logic done;
  logic [fcsu_pkg::DATA_W-1:0] rdata;
  modport master (output req, we, addr, wdata, input done, rdata);
  modport slave (input req, we, addr, wdata, output done, rdata);
endinterface

/* hw/fcsu_timer.sv */
// Poll timeout counter
`timescale 1ns/100ps
module fcsu_timer #(
  parameter int LIMIT = fcsu_pkg::POLL_LIMIT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic expired_o
);
  logic [31:0] cnt_q;
  // ==========================================================================
  // Counts while running, restarts whenever run drops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_q <= 32'h0000_0000;
      expired_o <= 1'b0;
    end else if (cnt_q == 32'(LIMIT - 1)) begin
      expired_o <= 1'b1; // Holds until run drops
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end
endmodule // fcsu_timer

/* hw/fcsu_bus_cycle.sv */
// Pin engine: one asynchronous write or read cycle on the flash bus
`timescale 1ns/100ps
module fcsu_bus_cycle (
  input wire logic clk_i,
  input wire logic rst_n_i,
  fcsu_cyc_if.slave cyc,
  input wire logic [fcsu_pkg::DATA_W-1:0] dq_i,
  output logic [fcsu_pkg::ADDR_W-1:0] addr_o,
  output logic [fcsu_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o
);
  typedef enum logic [1:0] {P_IDLE, P_STROBE, P_RECOVER} fcsu_phase_t;
  fcsu_phase_t phase_q;
  logic [7:0] cnt_q;
  logic wr_q;
  // ==========================================================================
  // Strobe low for the strobe time, then hold address and data while recovering
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_q <= P_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      case (phase_q)
        P_IDLE: begin
          if (cyc.req) begin
            phase_q <= P_STROBE;
            cnt_q <= 8'(fcsu_pkg::STROBE_CYC - 1);
            wr_q <= cyc.we;
            addr_o <= cyc.addr;
            dq_o <= cyc.wdata;
            dq_oe_o <= cyc.we;
            ce_n_o <= 1'b0;
            we_n_o <= !cyc.we;
            oe_n_o <= cyc.we;
          end
        end
        P_STROBE: begin
          if (cnt_q == 8'h00) begin
            phase_q <= P_RECOVER;
            cnt_q <= 8'(fcsu_pkg::RECOVER_CYC - 1);
            we_n_o <= 1'b1; // Device latches the write on this rising edge
            oe_n_o <= 1'b1;
            if (!wr_q) begin
              cyc.rdata <= dq_i;
            end
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          if (cnt_q == 8'h00) begin
            phase_q <= P_IDLE;
            ce_n_o <= 1'b1;
            dq_oe_o <= 1'b0;
            cyc.done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
      endcase
    end
  end
endmodule // fcsu_bus_cycle

/* verif/fcsu_flash_model.sv */
// Behavioural boot-block flash device with its status byte
`timescale 1ns/100ps
module fcsu_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h005a // Arbitrary value
) (
  // Clock, reset and fault knobs
  input wire logic clk_i,
  input wire logic rp_n_i,
  input wire logic supply_low_i,
  input wire logic fail_i,
  input wire logic slow_i,
  // Bus pins
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o
);
  logic [15:0] mem [16];
  logic [15:0] noise_q = 16'h0;
  logic [7:0] sr_q;
  logic [1:0] mode_q;
  logic [1:0] pend_q;
  logic [7:0] busy_q;
  logic we_q;
  logic erase_q;
  // Released bus toggles every cycle so a stale value never looks valid
  assign dq_o = (ce_n_i | oe_n_i) ? noise_q : (mode_q == 2'd2) ? {8'h00, sr_q} :
    (mode_q == 2'd1) ? (addr_i[0] ? PART_CODE : MAKER_CODE) : mem[addr_i[3:0]];
  // Command decoder and write engine, all 16 words in one erase block
  always @(posedge clk_i) begin
    we_q <= we_n_i;
    noise_q <= ~noise_q;
    if (!rp_n_i) begin
      mode_q <= 2'd0;
      sr_q <= 8'h87;
      pend_q <= 2'd0;
      busy_q <= 8'h00;
    end else begin
      if (busy_q != 8'h00 && !sr_q[6]) begin
        busy_q <= busy_q - 8'h01;
        if (busy_q == 8'h01) begin
          sr_q[7] <= 1'b1;
          if (fail_i) sr_q[erase_q ? 5 : 4] <= 1'b1;
          if (erase_q && !fail_i) foreach (mem[i]) mem[i] <= 16'hffff;
        end
      end
      if (!we_q && we_n_i && !ce_n_i) begin
        if (pend_q != 2'd0) begin
          pend_q <= 2'd0;
          mode_q <= 2'd2;
          if (pend_q == 2'd2 && dq_i[7:0] != 8'hd0) sr_q[5:4] <= 2'b11;
          else if (supply_low_i || sr_q[3]) begin
            sr_q[3] <= 1'b1;
            sr_q[pend_q[1] ? 5 : 4] <= 1'b1;
          end else begin
            busy_q <= slow_i ? 8'h64 : 8'h06;
            sr_q[7] <= 1'b0;
            erase_q <= pend_q[1];
            if (!pend_q[1]) mem[addr_i[3:0]] <= dq_i;
          end
        end else begin
          case (dq_i[7:0])
            8'hff: mode_q <= 2'd0;
            8'h90: mode_q <= 2'd1;
            8'h70: mode_q <= 2'd2;
            8'h50: sr_q[5:3] <= 3'b000;
            8'h40, 8'h10: if (!sr_q[6]) pend_q <= 2'd1;
            8'h20: if (!sr_q[6]) pend_q <= 2'd2;
            8'hb0: if (busy_q != 8'h00) sr_q[7:6] <= 2'b11;
            8'hd0: if (sr_q[6]) sr_q[7:6] <= 2'b00;
            default: ;
          endcase
        end
      end
    end
  end
endmodule // fcsu_flash_model

/* verif/flash_command_status_unit_tb.sv */
// Self-checking bench of the flash command and status controller
`timescale 1ns/100ps
module flash_command_status_unit_tb;
  typedef struct packed {
    logic [2:0] op;
    logic [19:0] ad;
    logic [15:0] d;
    logic [3:0] rg;
    logic [31:0] ex;
  } fcsu_row_t;
  localparam logic [3:0] ST = fcsu_pkg::REG_STATUS;
  localparam logic [3:0] RD = fcsu_pkg::REG_RDATA;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic low = 1'b0;
  logic fail = 1'b0, slow = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [19:0] fa;
  logic [15:0] fo;
  logic [15:0] fi;
  logic oe, ce_n, we_n, oe_n, rp_n;
  wire logic [15:0] dq = oe ? fo : fi;
  int num_errors = 0;
  int total_checks = 0;
  fcsu_row_t rows [7];
  fcsu_ctrl #(.POLL_LIMIT(50)) u_dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .ADDR_I(ra),
    .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .FL_ADDR_O(fa), .FL_DQ_I(dq),
    .FL_DQ_O(fo), .FL_DQ_OE_O(oe), .FL_CE_N_O(ce_n), .FL_WE_N_O(we_n), .FL_OE_N_O(oe_n),
    .FL_RP_N_O(rp_n));
  fcsu_flash_model u_flash (.clk_i(clk), .rp_n_i(rp_n), .supply_low_i(low), .fail_i(fail),
    .slow_i(slow), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fa), .dq_i(dq), .dq_o(fi));
  // ==========================================================================
  // Clock, watchdog and bus tasks
  initial begin
    forever #5 clk = ~clk;
  end
  // Whole run is under a thousand cycles, so 300 us means a hang
  initial begin
    #300000;
    num_errors++;
    tally_and_finish();
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    total_checks++;
    if (seen !== ex) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdat;
  endtask
  task automatic run(input logic [4:0] op, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    reg_wr(fcsu_pkg::REG_ADDR, {12'h0, a});
    reg_wr(fcsu_pkg::REG_WDATA, {16'h0, d});
    reg_wr(fcsu_pkg::REG_CTRL, {27'h0, op});
    @(posedge clk);
    do begin
      reg_rd(ST);
      n++;
    end while (q[0] !== 1'b0 && n < 200);
    if (q[0] !== 1'b0) num_errors++;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    rows[0] = '{3'd4, 20'h5, 16'h1234, ST, 32'h8000};
    rows[1] = '{3'd0, 20'h5, 16'h0, RD, 32'h1234};
    rows[2] = '{3'd1, 20'h0, 16'h0, RD, 32'h00a5};
    rows[3] = '{3'd1, 20'h1, 16'h0, RD, 32'h005a};
    rows[4] = '{3'd2, 20'h0, 16'h0, RD, 32'h0087};
    rows[5] = '{3'd5, 20'h3000, 16'h0, ST, 32'h8000};
    rows[6] = '{3'd0, 20'h5, 16'h0, RD, 32'hffff};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(ST);
    chk("status after reset", q, 32'h0);
    reg_rd(4'hf);
    chk("unmapped read", q, 32'h0);
    repeat (20) @(posedge clk);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].ad, rows[i].d);
      reg_rd(rows[i].rg);
      chk("table row", q, rows[i].ex);
    end
    low <= 1'b1;
    run(3'd4, 20'h6, 16'h0001);
    chk("low supply", q & 32'hff20, 32'h9820);
    low <= 1'b0;
    run(3'd5, 20'h6, 16'h0001);
    chk("refused", q & 32'h4, 32'h4);
    run(3'd3, 20'h0, 16'h0);
    run(3'd4, 20'h6, 16'h0001);
    chk("after clear", q & 32'hff20, 32'h8000);
    fail <= 1'b1;
    run(3'd5, 20'h0, 16'h0);
    fail <= 1'b0;
    run(5'h15, 20'h0, 16'h0);
    chk("wipe fault kept", q & 32'hff00, 32'ha000);
    run(3'd3, 20'h0, 16'h0);
    run(3'd5, 20'h0, 16'h0);
    chk("wipe fault cleared", q & 32'hff00, 32'h8000);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(ST);
    chk("status after reset", q, 32'h0);
    slow <= 1'b1;
    run(3'd5, 20'h0, 16'h0);
    chk("erase timeout", q & 32'h8, 32'h8);
    run(3'd6, 20'h0, 16'h0);
    chk("suspended", q & 32'hff06, 32'hc002);
    run(3'd4, 20'h6, 16'h0001);
    chk("refused in suspend", q & 32'hff06, 32'hc006);
    run(3'd7, 20'h0, 16'h0);
    chk("resumed", q & 32'hff02, 32'h8000);
    tally_and_finish();
  end
endmodule // flash_command_status_unit_tb
